/* src/adc_acquisition_sequencer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_acquisition_sequencer (
    // clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rstn,
    // configuration bits
    input  wire logic              timebase_chain_select,
    input  wire logic              stop_trigger_mode,
    input  wire logic              external_start_trigger_enable,
    // counter mode writes
    input  wire logic              interval_mode_wr,
    input  wire logic              timebase_mode_wr,
    input  wire logic [7:0]        mode_data,
    // counter data writes
    input  wire logic              interval_data_wr,
    input  wire logic              sample_data_wr,
    input  wire logic              timebase_data_wr,
    input  wire logic [7:0]        counter_data,
    // clear and result read
    input  wire logic              converter_clear_wr,
    input  wire logic              fifo_rd,
    output logic [`RES_W-1:0]      fifo_rd_data,
    // external timing
    input  wire logic              external_trigger_in,
    input  wire logic              external_convert_strobe_n,
    // converter
    output logic                   conv_start,
    input  wire logic              conv_done,
    input  wire logic [`RES_W-1:0] conv_result,
    // status
    output logic [7:0]             status,
    output logic                   interval_counter_output,
    output logic                   sample_counter_output,
    output logic                   conversion_gate
);
    localparam int DIVS [2] = '{`TB1_DIV, `TB2_DIV};

    logic [1:0]          rst_pipe_r;
    logic                rst_n;
    logic                tick_1mhz;
    logic                tick_2mhz;
    logic                tb_out;
    logic                tb_prev_r;
    logic                interval_tick;
    logic                interval_counter_out;
    logic                sample_counter_out;
    logic                a0_prev_r;
    logic                a0_fall;
    logic                trig_prev_r;
    logic                trig_rise;
    logic                trig_seen_r;
    logic                strobe_prev_r;
    logic                strobe_rise;
    logic                strobe_fall;
    logic                strobe_armed_r;
    logic                posttrig;
    logic                gate_r;
    logic                gate_nxt;
    logic                start_evt;
    logic                conv_start_r;
    logic                busy_r;
    logic                overflow_r;
    logic                overrun_r;
    logic [7:0]          status_r;
    logic [7:0]          status_nxt;
    logic [`RES_W-1:0]   rd_data_r;
    logic                res_valid;
    logic [`RES_W-1:0]   res_data;
    logic                a0_mode_wr;
    logic                a1_mode_wr;

    result_stream_if #(.WIDTH(`RES_W)) push_s ();

    // reset release through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_r <= 2'h0;
        end else begin
            rst_pipe_r <= {rst_pipe_r[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_r[1];

    // fixed timebases; 2 MHz divides 25 MHz by 12, the 12.5 truncated
    genvar g;
    for (g = 0; g < 2; g++) begin : gen_div
        logic [`DIV_W-1:0] cnt_r;
        logic              tick_r;
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_r  <= '0;
                tick_r <= 1'b0;
            end else if (cnt_r == `DIV_W'(DIVS[g] - 1)) begin
                cnt_r  <= '0;
                tick_r <= 1'b1;
            end else begin
                cnt_r  <= cnt_r + 1'b1;
                tick_r <= 1'b0;
            end
        end
    end
    assign tick_1mhz = gen_div[0].tick_r;
    assign tick_2mhz = gen_div[1].tick_r;

    // timebase counter, software writes the square wave mode byte
    rate_counter u_timebase (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .tick    (tick_2mhz),
        .gate    (1'b1),
        .mode_wr (timebase_mode_wr),
        .mode    (adc_seq_pkg::decode_mode(mode_data)),
        .data_wr (timebase_data_wr),
        .data    (counter_data),
        .out     (tb_out)
    );

    assign interval_tick = timebase_chain_select ?
                           (tb_out && !tb_prev_r) : tick_1mhz;
    assign a0_mode_wr = interval_mode_wr &&
                        adc_seq_pkg::sel_hits(mode_data, `SEL_CNT0);
    assign a1_mode_wr = interval_mode_wr &&
                        adc_seq_pkg::sel_hits(mode_data, `SEL_CNT1);

    // interval counter; count N gives N ticks per period
    rate_counter u_interval (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .tick    (interval_tick),
        .gate    (!posttrig || trig_seen_r),
        .mode_wr (a0_mode_wr),
        .mode    (adc_seq_pkg::decode_mode(mode_data)),
        .data_wr (interval_data_wr),
        .data    (counter_data),
        .out     (interval_counter_out)
    );

    // sample counter counts starts; in stop mode only after trigger
    rate_counter u_sample (
        .clk     (ref_clk),
        .rst_n   (rst_n),
        .tick    (start_evt),
        .gate    (!stop_trigger_mode || trig_seen_r),
        .mode_wr (a1_mode_wr),
        .mode    (adc_seq_pkg::decode_mode(mode_data)),
        .data_wr (sample_data_wr),
        .data    (counter_data),
        .out     (sample_counter_out)
    );

    // edge history of counter outputs and pins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tb_prev_r     <= 1'b1;
            a0_prev_r     <= 1'b1;
            trig_prev_r   <= 1'b0;
            strobe_prev_r <= 1'b1;
        end else begin
            tb_prev_r     <= tb_out;
            a0_prev_r     <= interval_counter_out;
            trig_prev_r   <= external_trigger_in;
            strobe_prev_r <= external_convert_strobe_n;
        end
    end
    assign trig_rise   = external_trigger_in && !trig_prev_r;
    assign strobe_rise = external_convert_strobe_n && !strobe_prev_r;
    assign strobe_fall = !external_convert_strobe_n && strobe_prev_r;
    assign a0_fall     = !interval_counter_out && a0_prev_r;

    assign posttrig = external_start_trigger_enable &&
                      !stop_trigger_mode;

    // trigger latch, dropped while the sample counter output is high
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_seen_r <= 1'b0;
        end else if (sample_counter_out || a1_mode_wr) begin
            trig_seen_r <= 1'b0;
        end else if (trig_rise) begin
            trig_seen_r <= 1'b1;
        end
    end

    // in posttrigger mode the strobe needs a rising edge after the trigger before it counts
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_armed_r <= 1'b0;
        end else if (!trig_seen_r) begin
            strobe_armed_r <= 1'b0;
        end else if (strobe_rise) begin
            strobe_armed_r <= 1'b1;
        end
    end

    // with no trigger bit set the gate follows the sample counter alone
    assign gate_nxt = !sample_counter_out &&
                      (stop_trigger_mode || !external_start_trigger_enable ||
                       trig_seen_r);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_r <= 1'b0;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    assign start_evt = gate_r && (a0_fall || (strobe_fall &&
                       (!posttrig || strobe_armed_r)));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start_r <= 1'b0;
        end else begin
            conv_start_r <= start_evt;
        end
    end

    // busy spans start to done; a new start wins over a done
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (start_evt) begin
            busy_r <= 1'b1;
        end else if (conv_done) begin
            busy_r <= 1'b0;
        end
    end

    // error flags; a fresh event wins over a clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            overrun_r <= 1'b0;
        end else if (start_evt && busy_r && !conv_done) begin
            overrun_r <= 1'b1;
        end else if (converter_clear_wr) begin
            overrun_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            overflow_r <= 1'b0;
        end else if (conv_done && !push_s.ready) begin
            overflow_r <= 1'b1;
        end else if (converter_clear_wr) begin
            overflow_r <= 1'b0;
        end
    end

    // result path; a full fifo refuses the word so it is dropped
    assign push_s.valid = conv_done;
    assign push_s.data  = conv_result;
    assign push_s.flush = converter_clear_wr;

    result_fifo #(.WIDTH(`RES_W), .DEPTH(`RES_DEPTH)) u_fifo (
        .clk       (ref_clk),
        .rst_n     (rst_n),
        .in_s      (push_s),
        .out_valid (res_valid),
        .out_ready (fifo_rd),
        .out_data  (res_data)
    );

    // a read of an empty fifo keeps the last word
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_r <= '0;
        end else if (fifo_rd && res_valid && !converter_clear_wr) begin
            rd_data_r <= res_data;
        end
    end

    always_comb begin
        status_nxt               = `ST_RESET;
        status_nxt[`ST_AVAIL]    = res_valid;
        status_nxt[`ST_OVERFLOW] = overflow_r;
        status_nxt[`ST_OVERRUN]  = overrun_r;
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_r <= `ST_RESET;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign fifo_rd_data            = rd_data_r;
    assign conv_start              = conv_start_r;
    assign status                  = status_r;
    assign interval_counter_output = interval_counter_out;
    assign sample_counter_output   = sample_counter_out;
    assign conversion_gate         = gate_r;

    gate_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        sample_counter_out |=> !gate_r)
        else $error("gate open while sample output high");
    post_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        posttrig && !trig_seen_r |=> !gate_r ##1 !conv_start_r)
        else $error("posttrigger gate opened before trigger");
    start_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !gate_r |=> !conv_start_r)
        else $error("conversion started through closed gate");
    avail_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_done && push_s.ready && !converter_clear_wr
        |=> ##1 status_r[`ST_AVAIL])
        else $error("available flag missing after stored result");
    overflow_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        conv_done && !push_s.ready |=> status_nxt[`ST_OVERFLOW]
        ##1 status_r[`ST_OVERFLOW])
        else $error("overflow not reported");
    overrun_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        start_evt && busy_r && !conv_done |=> overrun_r ##1 status_r[`ST_OVERRUN])
        else $error("overrun not reported");
    clear_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        converter_clear_wr && !conv_done && !start_evt
        |=> !overflow_r && !overrun_r && !res_valid)
        else $error("clear left flags or data");
endmodule // adc_acquisition_sequencer
`default_nettype wire

/* src/adc_seq_cfg.svh */
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// clock rates and divider counts
`define REF_CLK_HZ   25000000
`define TB1_HZ       1000000
`define TB2_HZ       2000000
`define TB1_DIV      (`REF_CLK_HZ / `TB1_HZ)
`define TB2_DIV      (`REF_CLK_HZ / `TB2_HZ)
`define DIV_W        5

// mode byte layout
`define SEL_MSB      7
`define SEL_LSB      6
`define MODE_MSB     3
`define MODE_LSB     1
`define SEL_CNT0     2'h0
`define SEL_CNT1     2'h1
`define MODE_CODE_TC 3'h0
`define MODE_CODE_RT 3'h2
`define MODE_CODE_SQ 3'h3

// status byte layout
`define ST_AVAIL     0
`define ST_OVERFLOW  1
`define ST_OVERRUN   2
`define ST_RESET     8'h00

// result path and counter width
`define RES_W        16
`define RES_DEPTH    16
`define CNT_W        16

`endif

/* src/adc_seq_pkg.sv */
`include "adc_seq_cfg.svh"
`default_nettype none

package adc_seq_pkg;

    typedef enum logic [1:0] {
        MODE_TC,
        MODE_RATE,
        MODE_SQUARE,
        MODE_OTHER
    } cnt_mode_type;

    function automatic cnt_mode_type decode_mode(input logic [7:0] b);
        unique case (b[`MODE_MSB:`MODE_LSB])
            `MODE_CODE_TC: decode_mode = MODE_TC;
            `MODE_CODE_RT: decode_mode = MODE_RATE;
            `MODE_CODE_SQ: decode_mode = MODE_SQUARE;
            default:       decode_mode = MODE_OTHER;
        endcase
    endfunction

    function automatic logic sel_hits(input logic [7:0] b,
                                      input logic [1:0] sel);
        sel_hits = (b[`SEL_MSB:`SEL_LSB] == sel);
    endfunction

endpackage
`default_nettype wire

/* src/result_stream_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface result_stream_if #(parameter int WIDTH = 16);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;
    logic             flush;
    modport producer (output valid, output data, output flush, input ready);
    modport consumer (input valid, input data, input flush, output ready);
endinterface
`default_nettype wire

/* src/result_fifo.sv */
`timescale 1ns/1ns
`default_nettype none
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // fill side
    result_stream_if.consumer     in_s,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_r;
    logic [AW-1:0]    rd_ptr_r;
    logic [AW:0]      count_r;
    logic             push;
    logic             pop;

    // a flush wins over a push so a clear always leaves it empty
    assign in_s.ready = (count_r != (AW+1)'(DEPTH));
    assign out_valid  = (count_r != '0);
    assign out_data   = mem[rd_ptr_r];
    assign push       = in_s.valid && in_s.ready && !in_s.flush;
    assign pop        = out_valid && out_ready && !in_s.flush;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_s.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else if (in_s.flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // result_fifo
`default_nettype wire

/* src/rate_counter.sv */
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"
module rate_counter (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // counting
    input  wire logic                      tick,
    input  wire logic                      gate,
    // software access
    input  wire logic                      mode_wr,
    input  wire adc_seq_pkg::cnt_mode_type mode,
    input  wire logic                      data_wr,
    input  wire logic [7:0]                data,
    // output
    output logic                           out
);
    adc_seq_pkg::cnt_mode_type mode_r;
    logic [`CNT_W-1:0] load_r;
    logic [`CNT_W-1:0] count_r;
    logic              high_next_r;
    logic              armed_r;
    logic              out_r;

    assign out = out_r;

    // byte pointer and load: low byte first, count starts after high byte
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            high_next_r <= 1'b0;
            load_r      <= '0;
        end else if (mode_wr) begin
            high_next_r <= 1'b0;
        end else if (data_wr) begin
            high_next_r <= !high_next_r;
            if (high_next_r) begin
                load_r[15:8] <= data;
            end else begin
                load_r[7:0] <= data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r  <= adc_seq_pkg::MODE_OTHER;
            armed_r <= 1'b0;
            count_r <= '0;
            out_r   <= 1'b1;
        end else if (mode_wr) begin
            mode_r  <= mode;
            armed_r <= 1'b0;
            out_r   <= (mode != adc_seq_pkg::MODE_TC);
        end else if (data_wr && high_next_r) begin
            armed_r <= 1'b1;
            count_r <= {data, load_r[7:0]};
        end else if (tick && gate && armed_r) begin
            unique case (mode_r)
                adc_seq_pkg::MODE_TC: begin
                    if (count_r != '0) begin
                        count_r <= count_r - 1'b1;
                    end
                    if (count_r == `CNT_W'(1)) begin
                        out_r <= 1'b1;
                    end
                end
                adc_seq_pkg::MODE_RATE: begin
                    // low for one tick per period
                    if (count_r <= `CNT_W'(1)) begin
                        count_r <= load_r;
                        out_r   <= 1'b1;
                    end else begin
                        count_r <= count_r - 1'b1;
                        out_r   <= (count_r != `CNT_W'(2));
                    end
                end
                adc_seq_pkg::MODE_SQUARE: begin
                    if (count_r <= `CNT_W'(1)) begin
                        count_r <= load_r;
                        out_r   <= 1'b1;
                    end else begin
                        count_r <= count_r - 1'b1;
                        if (count_r == (load_r >> 1) + `CNT_W'(1)) begin
                            out_r <= 1'b0;
                        end
                    end
                end
                adc_seq_pkg::MODE_OTHER: begin
                    out_r <= 1'b1;
                end
            endcase
        end
    end

    rate_high_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_wr && mode == adc_seq_pkg::MODE_RATE |=> out_r ##1 out_r)
        else $error("rate mode write did not drive output high");
    tc_low_a: assert property (@(posedge clk) disable iff (!rst_n)
        mode_wr && mode == adc_seq_pkg::MODE_TC |=> !out_r)
        else $error("terminal count mode write did not force output low");
endmodule // rate_counter
`default_nettype wire

/* sim/converter_model.sv */
`timescale 1ns/1ns
`default_nettype none
module converter_model (
    // clock and reset
    input  wire logic   clk,
    input  wire logic   rstn,
    // converter handshake
    input  wire logic   start,
    input  wire logic   slow,
    output logic        done,
    output logic [15:0] result
);
    int          wait_r;
    logic [15:0] seq_r;
    // junk between answers so a stale word never passes
    assign result = done ? seq_r : ~seq_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wait_r <= 0;
            seq_r  <= 16'h0100;
            done   <= 1'b0;
        end else begin
            done <= (wait_r == 1);
            if (done)
                seq_r <= seq_r + 16'h0001;
            // slow answers outlast the interval to provoke overrun
            if (start)
                wait_r <= slow ? 150 : 10;
            else if (wait_r != 0)
                wait_r <= wait_r - 1;
        end
    end
endmodule // converter_model
`default_nettype wire

/* sim/adc_acquisition_sequencer_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_cfg.svh"
module adc_acquisition_sequencer_test;
    localparam int IM = 0;
    localparam int TM = 1;
    localparam int SD = 3;
    localparam int TD = 4;
    localparam int ID = 2;
    localparam int CL = 5;
    logic        clk, rstn, stop, sten, trig, strb_n, rd, slow;
    logic        cs, cd, io, so, g, tbs;
    logic [5:0]  wv;
    logic [7:0]  d, st;
    logic [15:0] rdd, cres, v, e;
    int          fail_count, comparisons, ns, x, p;

    adc_acquisition_sequencer i_adc_acquisition_sequencer (
        .ref_clk(clk), .rstn(rstn), .timebase_chain_select(tbs),
        .stop_trigger_mode(stop), .external_start_trigger_enable(sten),
        .interval_mode_wr(wv[0]), .timebase_mode_wr(wv[1]),
        .mode_data(d), .interval_data_wr(wv[2]), .sample_data_wr(wv[3]),
        .timebase_data_wr(wv[4]), .counter_data(d),
        .converter_clear_wr(wv[5]), .fifo_rd(rd), .fifo_rd_data(rdd),
        .external_trigger_in(trig), .external_convert_strobe_n(strb_n),
        .conv_start(cs), .conv_done(cd), .conv_result(cres),
        .status(st), .interval_counter_output(io),
        .sample_counter_output(so), .conversion_gate(g));

    converter_model i_converter_model (.clk(clk), .rstn(rstn), .start(cs),
        .slow(slow), .done(cd), .result(cres));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) if (cs === 1'b1) ns++;

    task summarize;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task chk(input logic [15:0] s, input logic [15:0] t);
        comparisons++;
        if (s !== t) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, t);
        end
    endtask

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task wr(input int k, input logic [7:0] b);
        cyc(1);
        wv[k] = 1'b1;
        d = b;
        cyc(1);
        wv = '0;
    endtask

    task rdf(output logic [15:0] q);
        cyc(1);
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        q = rdd;
    endtask

    // bounded wait on one status bit
    task wt(input int b, input int lim);
        for (int i = 0; i < lim && st[b] !== 1'b1; i++)
            cyc(1);
        if (st[b] !== 1'b1) begin
            fail_count++;
            summarize();
        end
    endtask

    // spacing outlasts a fast conversion so no overrun
    task pulse;
        strb_n = 1'b0;
        cyc(8);
        strb_n = 1'b1;
        cyc(8);
    endtask

    // cycles between two conversion starts
    task per(output int q);
        int n;
        n = 0;
        while (n < 3000 && cs !== 1'b1) begin
            n++;
            cyc(1);
        end
        cyc(1);
        q = 1;
        while (q < 3000 && cs !== 1'b1) begin
            q++;
            cyc(1);
        end
        if (n == 3000 || q == 3000) begin
            fail_count++;
            summarize();
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        summarize();
    end

    initial begin
        {rstn, stop, sten, trig, rd, slow, wv, d} = '0;
        strb_n = 1'b1;
        tbs = 1'b0;
        {fail_count, comparisons, ns} = '0;
        repeat (12) @(posedge clk);
        #1 rstn = 1'b1;
        chk({st, io, so, g}, {8'h00, 3'b110});
        cyc(3);
        $display("reset test done");
        wr(IM, 8'h34);
        cyc(2);
        chk(io, 1'b1);
        wr(IM, 8'h70);
        cyc(3);
        chk(so, 1'b0);
        chk(g, 1'b1);
        wr(CL, 8'h00);
        rdf(v);
        cyc(2);
        chk(st, 8'h00);
        wr(ID, 8'h04);
        wr(ID, 8'h00);
        e = 16'h0100;
        wt(0, 400);
        rdf(v);
        chk(v, e);
        e++;
        per(p);
        chk(p[15:0], 16'(4 * `TB1_DIV));
        $display("freerun test done");
        wt(1, 2500);
        chk(st[1], 1'b1);
        for (int i = 0; i < 16; i++) begin
            rdf(v);
            chk(v, e + i[15:0]);
        end
        wr(IM, 8'h34);
        cyc(20);
        wr(CL, 8'h00);
        cyc(2);
        chk(st, 8'h00);
        $display("overflow test done");
        slow = 1'b1;
        wr(ID, 8'h04);
        wr(ID, 8'h00);
        wt(2, 400);
        chk(st[2], 1'b1);
        slow = 1'b0;
        wr(IM, 8'h34);
        cyc(200);
        wr(CL, 8'h00);
        cyc(2);
        chk(st, 8'h00);
        $display("overrun test done");
        tbs = 1'b1;
        wr(TM, 8'h36);
        wr(TD, 8'h04);
        wr(TD, 8'h00);
        wr(ID, 8'h02);
        wr(ID, 8'h00);
        per(p);
        chk(p[15:0], 16'(2 * 4 * `TB2_DIV));
        wr(IM, 8'h34);
        tbs = 1'b0;
        cyc(20);
        wr(CL, 8'h00);
        cyc(2);
        chk(st, 8'h00);
        $display("timebase test done");
        // sample counter held high closes the gate
        wr(IM, 8'h78);
        cyc(3);
        chk(g, 1'b0);
        x = ns;
        pulse();
        chk(ns - x, 0);
        sten = 1'b1;
        wr(IM, 8'h70);
        cyc(3);
        chk(g, 1'b0);
        pulse();
        chk(ns - x, 0);
        trig = 1'b1;
        cyc(4);
        chk(g, 1'b1);
        pulse();
        chk(ns - x, 0);
        pulse();
        chk(ns - x, 1);
        trig = 1'b0;
        $display("posttrigger test done");
        wr(IM, 8'h78);
        cyc(3);
        stop = 1'b1;
        wr(IM, 8'h70);
        cyc(3);
        chk(g, 1'b1);
        wr(SD, 8'h03);
        wr(SD, 8'h00);
        x = ns;
        pulse();
        chk(ns - x, 1);
        trig = 1'b1;
        cyc(2);
        repeat (3) pulse();
        chk({so, g}, 2'b10);
        pulse();
        chk(ns - x, 4);
        $display("pretrigger test done");
        summarize();
    end
endmodule // adc_acquisition_sequencer_test
`default_nettype wire
